//--- verilog/mpt_pkg.sv
package mpt_pkg;

    // channel index layout inside the trigger and status vectors
    localparam int CH_COUNT = 3;
    localparam int CH_MASTER = 0;
    localparam int CH_SLAVE1 = 1;
    localparam int CH_SLAVE2 = 2;

    // reset values, plus the zero and halt compare values
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_HALT = 16'hFFFF;
    localparam logic [2:0] ENABLE_RESET = 3'h0;
    localparam logic OUT_RESET = 1'b0;

    // count clock divider: system clocks per count clock tick
    localparam int TCLK_DIV_DEFAULT = 1;

    // per-slave output settings carried together
    typedef struct packed {
        logic output_value;
        logic output_enable;
        logic polarity;
        logic output_mode;
    } mpt_slave_cfg_type;

endpackage : mpt_pkg

//--- verilog/mpt_timer.sv
`timescale 1ns/1ps
module mpt_timer #(
    parameter int TCLK_DIV = mpt_pkg::TCLK_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] channel_start_trigger,
    input wire logic [2:0] channel_stop_trigger,
    input wire logic [15:0] master_period_value,
    input wire logic [15:0] slave1_duty_value,
    input wire logic [15:0] slave2_duty_value,
    input wire mpt_pkg::mpt_slave_cfg_type slave1_cfg,
    input wire mpt_pkg::mpt_slave_cfg_type slave2_cfg,
    output logic [2:0] channel_enable_status,
    output logic [15:0] master_counter,
    output logic [15:0] slave1_counter,
    output logic [15:0] slave2_counter,
    output logic master_period_irq,
    output logic slave1_pwm_out,
    output logic slave2_pwm_out
);

    logic [15:0] div_reg;
    logic tick;
    logic master_zero;
    logic irq_tick_reg;
    logic [2:0] en_reg;
    logic [15:0] mcnt_reg;
    logic [15:0] s1cnt_reg;
    logic [15:0] s2cnt_reg;
    logic s1_act_reg;
    logic s2_act_reg;
    logic s1_out_next;
    logic s2_out_next;

    // count clock enable; a divider of one gives a tick every clock
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            div_reg <= 16'h0000;
        else if (div_reg >= 16'(TCLK_DIV - 1))
            div_reg <= 16'h0000;
        else
            div_reg <= div_reg + 16'h0001;
    end
    assign tick = (div_reg >= 16'(TCLK_DIV - 1));

    assign master_zero = en_reg[mpt_pkg::CH_MASTER] && tick && (mcnt_reg == mpt_pkg::CNT_ZERO);

    // enable status; trigger inputs are one-cycle pulses, so nothing holds them (self clearing)
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            en_reg <= mpt_pkg::ENABLE_RESET;
        else
            en_reg <= (en_reg & ~channel_stop_trigger) | channel_start_trigger;
    end

    // master counter: load on a start from stopped, reload on zero, hold when stopped
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mcnt_reg <= mpt_pkg::CNT_RESET;
        else if (channel_start_trigger[mpt_pkg::CH_MASTER] && !en_reg[mpt_pkg::CH_MASTER])
            mcnt_reg <= master_period_value;
        else if (master_zero)
            mcnt_reg <= master_period_value;
        else if (en_reg[mpt_pkg::CH_MASTER] && tick)
            mcnt_reg <= mcnt_reg - 16'h0001;
    end // holds when stopped

    // period interrupt pulse, registered so the output comes from a flop
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            master_period_irq <= 1'b0;
        else
            master_period_irq <= master_zero;
    end

    // remembers an interrupt until the next tick so the active edge lands one count clock later
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_tick_reg <= 1'b0;
        else if (master_zero)
            irq_tick_reg <= 1'b1;
        else if (tick)
            irq_tick_reg <= 1'b0;
    end

    // slave 1 counter: reload on interrupt, count through zero, park at FFFFH
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            s1cnt_reg <= mpt_pkg::CNT_RESET;
        else if (master_zero && en_reg[mpt_pkg::CH_SLAVE1])
            s1cnt_reg <= slave1_duty_value;
        else if (en_reg[mpt_pkg::CH_SLAVE1] && tick && s1cnt_reg != mpt_pkg::CNT_HALT)
            s1cnt_reg <= s1cnt_reg - 16'h0001;
    end

    // slave 2 counter, same behaviour
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            s2cnt_reg <= mpt_pkg::CNT_RESET;
        else if (master_zero && en_reg[mpt_pkg::CH_SLAVE2])
            s2cnt_reg <= slave2_duty_value;
        else if (en_reg[mpt_pkg::CH_SLAVE2] && tick && s2cnt_reg != mpt_pkg::CNT_HALT)
            s2cnt_reg <= s2cnt_reg - 16'h0001;
    end

    // active state: set one tick after the interrupt, cleared on the tick that finds the counter at zero;
    // clearing there rather than at one keeps the pulse exactly duty ticks wide, and a zero duty never goes active
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            s1_act_reg <= 1'b0;
        else if (en_reg[mpt_pkg::CH_SLAVE1] && tick && irq_tick_reg)
            s1_act_reg <= (s1cnt_reg != mpt_pkg::CNT_ZERO);
        else if (en_reg[mpt_pkg::CH_SLAVE1] && tick && s1cnt_reg == mpt_pkg::CNT_ZERO)
            s1_act_reg <= 1'b0;
    end // held when stopped

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            s2_act_reg <= 1'b0;
        else if (en_reg[mpt_pkg::CH_SLAVE2] && tick && irq_tick_reg)
            s2_act_reg <= (s2cnt_reg != mpt_pkg::CNT_ZERO);
        else if (en_reg[mpt_pkg::CH_SLAVE2] && tick && s2cnt_reg == mpt_pkg::CNT_ZERO)
            s2_act_reg <= 1'b0;
    end

    // pin level: value bit when not enabled, else active state through polarity in slave mode
    always_comb
    begin
        if (!slave1_cfg.output_enable)
            s1_out_next = slave1_cfg.output_value;
        else if (slave1_cfg.output_mode)
            s1_out_next = s1_act_reg ^ slave1_cfg.polarity;
        else
            s1_out_next = s1_act_reg;
        if (!slave2_cfg.output_enable)
            s2_out_next = slave2_cfg.output_value;
        else if (slave2_cfg.output_mode)
            s2_out_next = s2_act_reg ^ slave2_cfg.polarity;
        else
            s2_out_next = s2_act_reg;
    end

    // registered pins and readback; counters are visible every cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            slave1_pwm_out <= mpt_pkg::OUT_RESET;
            slave2_pwm_out <= mpt_pkg::OUT_RESET;
            channel_enable_status <= mpt_pkg::ENABLE_RESET;
            master_counter <= mpt_pkg::CNT_RESET;
            slave1_counter <= mpt_pkg::CNT_RESET;
            slave2_counter <= mpt_pkg::CNT_RESET;
        end
        else
        begin
            slave1_pwm_out <= s1_out_next;
            slave2_pwm_out <= s2_out_next;
            channel_enable_status <= en_reg;
            master_counter <= mcnt_reg;
            slave1_counter <= s1cnt_reg;
            slave2_counter <= s2cnt_reg;
        end
    end

    // checks; a start on a running master is refused, so only a start from stopped must load
    a_start_sets_enable: assert property (@(posedge clk) disable iff (sys_rst)
        channel_start_trigger[0] && !en_reg[0] |=> en_reg[0] && mcnt_reg == $past(master_period_value))
        else $error("start did not load master");
    a_stop_clears_enable: assert property (@(posedge clk) disable iff (sys_rst)
        (channel_stop_trigger[0] && !channel_start_trigger[0]) |=> !en_reg[0])
        else $error("stop did not clear enable");
    a_irq_at_zero: assert property (@(posedge clk) disable iff (sys_rst)
        master_zero |=> master_period_irq)
        else $error("interrupt missing at zero");
    a_master_reload: assert property (@(posedge clk) disable iff (sys_rst)
        master_zero && !channel_start_trigger[0] |=> mcnt_reg == $past(master_period_value))
        else $error("master did not reload");
    a_slave_load: assert property (@(posedge clk) disable iff (sys_rst)
        master_zero && en_reg[1] && !channel_stop_trigger[1] |=> s1cnt_reg == $past(slave1_duty_value))
        else $error("slave did not load duty");
    a_slave_halt: assert property (@(posedge clk) disable iff (sys_rst)
        s1cnt_reg == 16'hFFFF && !master_zero |=> s1cnt_reg == 16'hFFFF)
        else $error("slave left halt without reload");
    a_hold_stopped: assert property (@(posedge clk) disable iff (sys_rst)
        !en_reg[0] && !channel_start_trigger[0] |=> $stable(mcnt_reg))
        else $error("master moved while stopped");
    a_active_clear: assert property (@(posedge clk) disable iff (sys_rst)
        en_reg[1] && tick && s1cnt_reg == 16'h0000 && !irq_tick_reg |=> !s1_act_reg)
        else $error("slave not inactive at zero");
    a_forced_level: assert property (@(posedge clk) disable iff (sys_rst)
        !slave1_cfg.output_enable |=> slave1_pwm_out == $past(slave1_cfg.output_value))
        else $error("disabled output not forced");
    c_period_irq: cover property (@(posedge clk) disable iff (sys_rst) master_period_irq);
    c_slave_active: cover property (@(posedge clk) disable iff (sys_rst) $rose(s1_act_reg));
    c_slave_halted: cover property (@(posedge clk) disable iff (sys_rst) s2cnt_reg == 16'hFFFF);
    c_stop_run: cover property (@(posedge clk) disable iff (sys_rst) en_reg[0] ##1 !en_reg[0]);
    c_master_mode: cover property (@(posedge clk) disable iff (sys_rst)
        en_reg[2] && !slave2_cfg.output_mode && s2_act_reg);

    // slave 2 follows the same load, halt, set and clear sequence as slave 1
    a_slave2_load: assert property (@(posedge clk) disable iff (sys_rst)
        master_zero && en_reg[2] |=> s2cnt_reg == $past(slave2_duty_value))
        else $error("slave 2 did not load duty");
    a_slave2_halt: assert property (@(posedge clk) disable iff (sys_rst)
        s2cnt_reg == 16'hFFFF && !master_zero |=> s2cnt_reg == 16'hFFFF)
        else $error("slave 2 left halt without reload");
    a_active_set: assert property (@(posedge clk) disable iff (sys_rst)
        en_reg[1] && tick && irq_tick_reg && s1cnt_reg != 16'h0000 |=> s1_act_reg)
        else $error("slave 1 not active one tick after interrupt");
    a_slave2_set: assert property (@(posedge clk) disable iff (sys_rst)
        en_reg[2] && tick && irq_tick_reg && s2cnt_reg != 16'h0000 |=> s2_act_reg)
        else $error("slave 2 not active one tick after interrupt");
    a_slave2_clear: assert property (@(posedge clk) disable iff (sys_rst)
        en_reg[2] && tick && s2cnt_reg == 16'h0000 && !irq_tick_reg |=> !s2_act_reg)
        else $error("slave 2 not inactive at zero");

    // pin shaping: polarity only counts in slave output mode
    a_polarity_sense: assert property (@(posedge clk) disable iff (sys_rst)
        slave1_cfg.output_enable && slave1_cfg.output_mode |=> slave1_pwm_out == ($past(s1_act_reg) ^ $past(slave1_cfg.polarity)))
        else $error("slave 1 polarity not applied");
    a_slave2_polarity: assert property (@(posedge clk) disable iff (sys_rst)
        slave2_cfg.output_enable && slave2_cfg.output_mode |=> slave2_pwm_out == ($past(s2_act_reg) ^ $past(slave2_cfg.polarity)))
        else $error("slave 2 polarity not applied");
    a_master_mode_level: assert property (@(posedge clk) disable iff (sys_rst)
        slave2_cfg.output_enable && !slave2_cfg.output_mode |=> slave2_pwm_out == $past(s2_act_reg))
        else $error("master output mode did not ignore polarity");

    // a stopped slave freezes both its count and its active state
    a_slave_frozen: assert property (@(posedge clk) disable iff (sys_rst)
        !en_reg[1] |=> $stable(s1cnt_reg) && $stable(s1_act_reg))
        else $error("slave 1 moved while stopped");
    a_slave2_frozen: assert property (@(posedge clk) disable iff (sys_rst)
        !en_reg[2] |=> $stable(s2cnt_reg) && $stable(s2_act_reg))
        else $error("slave 2 moved while stopped");

    // reset must leave the irq, enable status, master counter and both pins cleared at the following edge
    a_reset_clear: assert property (@(posedge clk)
        sys_rst |=> !master_period_irq && channel_enable_status == mpt_pkg::ENABLE_RESET
        && master_counter == mpt_pkg::CNT_RESET && !slave1_pwm_out && !slave2_pwm_out)
        else $error("outputs not cleared by reset");

    // helper: duty that slave 1 was last loaded with, kept apart from the counter itself
    logic [15:0] s1_duty_reg;
    logic [15:0] s1_width_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            s1_duty_reg <= mpt_pkg::CNT_RESET;
        else if (master_zero && en_reg[mpt_pkg::CH_SLAVE1])
            s1_duty_reg <= slave1_duty_value;
    end

    // helper: enabled ticks spent active; stopped time does not count, so a cut pulse still adds up
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            s1_width_reg <= mpt_pkg::CNT_RESET;
        else if (en_reg[mpt_pkg::CH_SLAVE1] && tick && irq_tick_reg)
            s1_width_reg <= mpt_pkg::CNT_ZERO;
        else if (en_reg[mpt_pkg::CH_SLAVE1] && tick && s1_act_reg)
            s1_width_reg <= s1_width_reg + 16'h0001;
    end
    a_active_width: assert property (@(posedge clk) disable iff (sys_rst)
        en_reg[1] && tick && s1_act_reg && s1cnt_reg == 16'h0000 && !irq_tick_reg
        |-> s1_width_reg + 16'h0001 == s1_duty_reg)
        else $error("slave 1 active width differs from its duty");

endmodule : mpt_timer

//--- dv/tb_top.sv
`timescale 1ns/1ps
// shared compare: counts every check and reports a mismatch at once
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    localparam logic [15:0] PER = 16'h0009;
    logic clk;
    logic sys_rst;
    logic [2:0] channel_start_trigger;
    logic [2:0] channel_stop_trigger;
    logic [15:0] master_period_value;
    logic [15:0] slave1_duty_value;
    logic [15:0] slave2_duty_value;
    mpt_pkg::mpt_slave_cfg_type slave1_cfg;
    mpt_pkg::mpt_slave_cfg_type slave2_cfg;
    logic [2:0] channel_enable_status;
    logic [15:0] master_counter;
    logic [15:0] slave1_counter;
    logic [15:0] slave2_counter;
    logic master_period_irq;
    logic slave1_pwm_out;
    logic slave2_pwm_out;
    logic [15:0] held [3];
    logic [1:0] held_out;
    int error_cnt;
    int samples_checked;
    int cycles;

    // one tick per clock keeps the period short enough to count by hand
    mpt_timer #(.TCLK_DIV(1)) dut (.clk, .sys_rst, .channel_start_trigger, .channel_stop_trigger,
        .master_period_value, .slave1_duty_value, .slave2_duty_value, .slave1_cfg, .slave2_cfg,
        .channel_enable_status, .master_counter, .slave1_counter, .slave2_counter,
        .master_period_irq, .slave1_pwm_out, .slave2_pwm_out);

    // free running clock, 40 ns period
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // hang guard: the whole run needs about 125 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            error_cnt++;
            summarize();
        end
    end

    task summarize;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // inputs move only at falling edges, outputs are settled there
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task wait_irq;
        int k;
        k = 0;
        while (master_period_irq !== 1'b1 && k < 100)
        begin
            step(1);
            k++;
        end
        `CHK("irq wait", 1'b1, master_period_irq)
    endtask : wait_irq

    // one full period from an irq to the next: active widths, first active slot, halt value
    task measure(input logic a1, input logic a2, input int h1x, input int h2x, input int f1x);
        int h1;
        int h2;
        int f1;
        logic early;
        h1 = 0;
        h2 = 0;
        f1 = 0;
        early = 1'b0;
        wait_irq();
        for (int k = 1; k <= PER + 1; k++)
        begin
            step(1);
            if (slave1_pwm_out === a1 && f1 == 0)
                f1 = k;
            if (slave1_pwm_out === a1)
                h1++;
            if (slave2_pwm_out === a2)
                h2++;
            if (k <= PER)
                early |= master_period_irq;
            if (k == PER)
            begin
                `CHK("slave1 halt", 16'hFFFF, slave1_counter)
                `CHK("slave2 halt", 16'hFFFF, slave2_counter)
            end
        end
        `CHK("irq period", 1'b1, master_period_irq)
        `CHK("irq early", 1'b0, early)
        `CHK("slave1 width", h1x, h1)
        `CHK("slave2 width", h2x, h2)
        `CHK("slave1 first", f1x, f1)
    endtask : measure

    task start_all;
        channel_start_trigger = 3'h7;
        step(1);
        channel_start_trigger = 3'h0;
        step(1);
        `CHK("start status", 3'h7, channel_enable_status)
    endtask : start_all

    initial
    begin
        sys_rst = 1'b1;
        channel_start_trigger = 3'h0;
        channel_stop_trigger = 3'h0;
        master_period_value = PER; // master settings are fixed before the start
        slave1_duty_value = 16'h0003;
        slave2_duty_value = 16'h0005;
        slave1_cfg = 4'h5;
        slave2_cfg = 4'h7;
        error_cnt = 0;
        samples_checked = 0;
        cycles = 0;
        step(20);
        `CHK("reset out", 2'h0, {slave1_pwm_out, slave2_pwm_out})
        sys_rst = 1'b0;
        step(1);
        `CHK("reset status", 3'h0, channel_enable_status)
        // idle slave 2 is active low, so its inactive level shows high once reset lets go
        `CHK("idle out", 2'h1, {slave1_pwm_out, slave2_pwm_out})
        start_all();
        `CHK("master load", 1'b1, master_counter == PER || master_counter == PER - 1)
        measure(1'b1, 1'b0, 3, 5, 2);
        measure(1'b1, 1'b0, 3, 5, 2);
        // retune only after a period event; the new duty takes effect at the next one, the new slave2_cfg at once
        wait_irq();
        slave1_duty_value = 16'h0006;
        slave2_cfg = 4'h5;
        step(1);
        measure(1'b1, 1'b1, 6, 5, 2);
        // enable off gives a constant level; enables may change while running
        slave1_cfg = 4'h9;
        step(1);
        measure(1'b1, 1'b1, 10, 5, 1);
        // stop while slave1 is active: everything must freeze where it is
        slave1_cfg = 4'h5;
        slave2_cfg = 4'h7;
        wait_irq();
        step(3);
        channel_stop_trigger = 3'h7;
        step(1);
        channel_stop_trigger = 3'h0;
        step(2);
        held = '{master_counter, slave1_counter, slave2_counter};
        held_out = {slave1_pwm_out, slave2_pwm_out};
        step(6);
        `CHK("stop status", 3'h0, channel_enable_status)
        `CHK("held master", held[0], master_counter)
        `CHK("held slave1", held[1], slave1_counter)
        `CHK("held slave2", held[2], slave2_counter)
        `CHK("held out", held_out, {slave1_pwm_out, slave2_pwm_out})
        `CHK("held active", 1'b1, slave1_pwm_out)
        // output mode may only change while stopped; enables stay set for the restart
        slave2_cfg = 4'h6;
        start_all();
        measure(1'b1, 1'b1, 6, 5, 2);
        summarize();
    end
endmodule : tb_top
